// >>> uirp_top.sv
// Purpose: Port-2 direction control and serial channel with infrared pulse framing.
// Assumes: Byte register port from the CPU; pins 0 to 5 of port 2 are three-signal pins.
// Notes:   Bit timing runs on a source tick enable; no second clock.
// Notes on behaviour
// - Reset loads the port-2 direction register with all ones so every pin is an input.
// - A direction bit of zero turns a pin's output buffer on and a one turns it off, for pins 0 to 5.
// - Infrared frames carry the UART bit sequence of one start, eight data and one stop bit.
// - Each infrared pulse lasts three sixteenths of a bit period.
// - Each infrared pulse starts at the middle of its bit period.
// - With a 7.3728 MHz main clock and the 10H setting the infrared link runs at 115.2 kbps.
// - In infrared mode received data lags the line pulses by half a bit period.
// - One mode bit picks UART or infrared, and separate enables switch transmit and receive.
// - The baud source is the external pin or the main clock over 1 to 7 powers of two, and a bit lasts 32 to 60 of its ticks.
`timescale 1ns/1ps
`default_nettype none
`include "uirp_regs.svh"
module uirp_top (
	// Clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	// CPU register port
	input  wire logic [15:0] reg_addr,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	input  wire logic [7:0]  reg_wdata,
	output logic [7:0]       reg_rdata,
	// Port-2 pins 0 to 5
	input  wire logic [5:0]  pin_in,
	output logic [5:0]       pin_out,
	output logic [5:0]       pin_oe_n
);
	logic [7:0]  port2_direction;
	logic [7:0]  port2_latch;
	logic        tx_enable_bit;
	logic        rx_enable_bit;
	logic        infrared_mode_select;
	logic [2:0]  baud_src_sel;
	logic [3:0]  baud_div_sel;
	logic [5:0]  pin_meta;
	logic [5:0]  pin_sync;
	logic [5:0]  pin_prev;
	logic [6:0]  prescale;
	logic        src_tick;
	logic [5:0]  bit_len;
	logic [5:0]  half_len;
	logic [5:0]  pulse_len;
	logic [7:0]  pulse_prod;
	logic        fifo_in_ready;
	logic        fifo_out_valid;
	logic [7:0]  fifo_out_data;
	logic        tx_push;
	logic        tx_take;
	uirp_pkg::uirp_tx_state_e tx_st;
	logic [5:0]  tx_phase;
	logic [2:0]  tx_bit;
	logic [7:0]  tx_shift;
	logic        tx_level;
	logic        ir_pulse;
	logic        tx_wrap;
	logic [5:0]  ir_hold;
	logic        rx_line;
	uirp_pkg::uirp_rx_state_e rx_st;
	logic [5:0]  rx_phase;
	logic [2:0]  rx_bit;
	logic [7:0]  rx_shift;
	logic [7:0]  rx_data;
	logic        rx_full;
	logic        rx_overrun;
	logic        rx_frame_err;
	logic        rx_sample;
	logic        rx_wrap;
	logic        rx_store;
	logic        rd_rx;
	logic        rd_status;
	logic [5:0]  pulse_ticks;

	function automatic logic hit(input logic [15:0] addr, input logic [15:0] target);
		hit = (addr == target);
	endfunction : hit

	// Low n bits of the prescaler; all ones there gives one tick per 2^n clocks
	function automatic logic [6:0] src_mask(input logic [2:0] n);
		src_mask = 7'(({7'h00, 1'b1} << n) - 8'h01);
	endfunction : src_mask

	assign tx_push   = reg_wr && hit(reg_addr, `UIRP_ADDR_TX_DATA);
	assign rd_rx     = reg_rd && hit(reg_addr, `UIRP_ADDR_RX_DATA);
	assign rd_status = reg_rd && hit(reg_addr, `UIRP_ADDR_STATUS);

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			port2_direction <= `UIRP_RST_PORT2_DIR;
			port2_latch     <= `UIRP_RST_ZERO;
		end else if (reg_wr && hit(reg_addr, `UIRP_ADDR_PORT2_DIR)) begin
			port2_direction <= reg_wdata | `UIRP_DIR_FIXED_MASK;
		end else if (reg_wr && hit(reg_addr, `UIRP_ADDR_PORT2_LATCH)) begin
			port2_latch <= reg_wdata;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			tx_enable_bit        <= 1'b0;
			rx_enable_bit        <= 1'b0;
			infrared_mode_select <= 1'b0;
			baud_src_sel         <= 3'h0;
			baud_div_sel         <= 4'h0;
		end else if (reg_wr && hit(reg_addr, `UIRP_ADDR_SERIAL_MODE)) begin
			tx_enable_bit        <= reg_wdata[`UIRP_MODE_TXE];
			rx_enable_bit        <= reg_wdata[`UIRP_MODE_RXE];
			infrared_mode_select <= reg_wdata[`UIRP_MODE_IR];
		end else if (reg_wr && hit(reg_addr, `UIRP_ADDR_BAUD_GEN)) begin
			baud_src_sel <= reg_wdata[`UIRP_BAUD_SRC_HI:`UIRP_BAUD_SRC_LO];
			baud_div_sel <= reg_wdata[`UIRP_BAUD_DIV_HI:`UIRP_BAUD_DIV_LO];
		end
	end

	// Pin inputs pass two flip-flops; the edge detectors compare the second with a third flip-flop holding its previous value
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			pin_meta <= 6'h3F;
			pin_sync <= 6'h3F;
			pin_prev <= 6'h3F;
		end else begin
			pin_meta <= pin_in;
			pin_sync <= pin_meta;
			pin_prev <= pin_sync;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			prescale <= 7'h00;
		end else begin
			prescale <= prescale + 7'h01;
		end
	end

	// The setting 15 is prohibited; it is clamped to 14 so the divider stays bounded
	always_comb begin
		src_tick = (baud_src_sel == 3'h0) ?
			(pin_sync[`UIRP_PIN_EXT] && !pin_prev[`UIRP_PIN_EXT]) :
			((prescale & src_mask(baud_src_sel)) == src_mask(baud_src_sel));
		half_len   = 6'(`UIRP_DIV_BASE + ((baud_div_sel > `UIRP_DIV_MAX) ? `UIRP_DIV_MAX : baud_div_sel));
		bit_len    = 6'(half_len << 1);
		pulse_prod = 8'(`UIRP_PULSE_NUM * {2'b00, bit_len});
		pulse_len  = 6'(pulse_prod >> `UIRP_PULSE_SHIFT);
	end

	uirp_fifo #(
		.WIDTH (8),
		.DEPTH (`UIRP_FIFO_DEPTH)
	) u_tx_fifo (
		.clk_sys   (clk_sys),
		.rst_n     (rst_n),
		.in_valid  (tx_push),
		.in_ready  (fifo_in_ready),
		.in_data   (reg_wdata),
		.out_valid (fifo_out_valid),
		.out_ready (tx_take),
		.out_data  (fifo_out_data)
	);

	assign tx_take = (tx_st == uirp_pkg::UIRP_TX_IDLE) && tx_enable_bit && fifo_out_valid && src_tick;
	assign tx_wrap = src_tick && (tx_phase == bit_len - 6'h01);

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			tx_st    <= uirp_pkg::UIRP_TX_IDLE;
			tx_phase <= 6'h00;
			tx_bit   <= 3'h0;
			tx_shift <= 8'h00;
			tx_level <= 1'b1;
		end else begin
			if (src_tick) begin
				tx_phase <= tx_wrap ? 6'h00 : tx_phase + 6'h01;
			end
			case (tx_st)
				uirp_pkg::UIRP_TX_IDLE: begin
					if (tx_take) begin
						tx_st    <= uirp_pkg::UIRP_TX_START;
						tx_phase <= 6'h00;
						tx_shift <= fifo_out_data;
						tx_level <= 1'b0;
					end
				end
				uirp_pkg::UIRP_TX_START: begin
					if (tx_wrap) begin
						tx_st    <= uirp_pkg::UIRP_TX_DATA;
						tx_bit   <= 3'h0;
						tx_level <= tx_shift[0];
					end
				end
				uirp_pkg::UIRP_TX_DATA: begin
					if (tx_wrap) begin
						if (tx_bit == 3'(`UIRP_DATA_BITS - 1)) begin
							tx_st    <= uirp_pkg::UIRP_TX_STOP;
							tx_level <= 1'b1;
						end else begin
							tx_bit   <= tx_bit + 3'h1;
							tx_level <= tx_shift[tx_bit + 3'h1];
						end
					end
				end
				uirp_pkg::UIRP_TX_STOP: begin
					if (tx_wrap) begin
						tx_st <= uirp_pkg::UIRP_TX_IDLE;
					end
				end
				default: begin
					tx_st <= uirp_pkg::UIRP_TX_IDLE;
				end
			endcase
		end
	end

	// Zero bits only, rising at mid-bit for 3/16 of the bit
	assign ir_pulse = infrared_mode_select && (tx_st != uirp_pkg::UIRP_TX_IDLE) && !tx_level
		&& (tx_phase >= half_len) && (tx_phase < half_len + pulse_len);

	// A latch left at one holds the shared pin high; software must clear it
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			pin_out  <= 6'h00;
			pin_oe_n <= 6'h3F;
		end else begin
			pin_oe_n <= port2_direction[5:0];
			pin_out  <= port2_latch[5:0];
			if (tx_enable_bit) begin
				pin_out[`UIRP_PIN_TX] <= port2_latch[`UIRP_PIN_TX]
					| (infrared_mode_select ? ir_pulse : tx_level);
			end
		end
	end

	// Each received pulse forces the internal line low for one bit, starting at mid-bit
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			ir_hold <= 6'h00;
		end else if (pin_sync[`UIRP_PIN_RX] && !pin_prev[`UIRP_PIN_RX]) begin
			ir_hold <= bit_len;
		end else if (src_tick && ir_hold != 6'h00) begin
			ir_hold <= ir_hold - 6'h01;
		end
	end

	assign rx_line   = infrared_mode_select ? (ir_hold == 6'h00) : pin_sync[`UIRP_PIN_RX];
	assign rx_sample = src_tick && (rx_phase == half_len);
	assign rx_wrap   = src_tick && (rx_phase == bit_len - 6'h01);
	assign rx_store  = (rx_st == uirp_pkg::UIRP_RX_STOP) && rx_sample;

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rx_st    <= uirp_pkg::UIRP_RX_IDLE;
			rx_phase <= 6'h00;
			rx_bit   <= 3'h0;
			rx_shift <= 8'h00;
		end else begin
			if (src_tick) begin
				rx_phase <= rx_wrap ? 6'h00 : rx_phase + 6'h01;
			end
			case (rx_st)
				uirp_pkg::UIRP_RX_IDLE: begin
					if (rx_enable_bit && !rx_line) begin
						rx_st    <= uirp_pkg::UIRP_RX_START;
						rx_phase <= 6'h00;
					end
				end
				uirp_pkg::UIRP_RX_START: begin
					if (rx_sample && rx_line) begin
						rx_st <= uirp_pkg::UIRP_RX_IDLE;
					end else if (rx_wrap) begin
						rx_st  <= uirp_pkg::UIRP_RX_DATA;
						rx_bit <= 3'h0;
					end
				end
				uirp_pkg::UIRP_RX_DATA: begin
					if (rx_sample) begin
						rx_shift <= {rx_line, rx_shift[7:1]};
					end
					if (rx_wrap) begin
						rx_bit <= rx_bit + 3'h1;
						if (rx_bit == 3'(`UIRP_DATA_BITS - 1)) begin
							rx_st <= uirp_pkg::UIRP_RX_STOP;
						end
					end
				end
				uirp_pkg::UIRP_RX_STOP: begin
					if (rx_sample) begin
						rx_st <= uirp_pkg::UIRP_RX_IDLE;
					end
				end
				default: begin
					rx_st <= uirp_pkg::UIRP_RX_IDLE;
				end
			endcase
		end
	end

	// A new byte wins over a read in the same cycle, so no flag set is lost
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rx_data      <= 8'h00;
			rx_full      <= 1'b0;
			rx_overrun   <= 1'b0;
			rx_frame_err <= 1'b0;
		end else begin
			if (rx_store) begin
				rx_data <= rx_shift;
				rx_full <= 1'b1;
			end else if (rd_rx) begin
				rx_full <= 1'b0;
			end
			if (rx_store && rx_full && !rd_rx) begin
				rx_overrun <= 1'b1;
			end else if (rd_status) begin
				rx_overrun <= 1'b0;
			end
			if (rx_store && !rx_line) begin
				rx_frame_err <= 1'b1;
			end else if (rd_status) begin
				rx_frame_err <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			reg_rdata <= 8'h00;
			if (hit(reg_addr, `UIRP_ADDR_PORT2_DIR)) begin
				reg_rdata <= port2_direction;
			end else if (hit(reg_addr, `UIRP_ADDR_PORT2_LATCH)) begin
				reg_rdata <= port2_latch;
			end else if (hit(reg_addr, `UIRP_ADDR_SERIAL_MODE)) begin
				reg_rdata[`UIRP_MODE_TXE] <= tx_enable_bit;
				reg_rdata[`UIRP_MODE_RXE] <= rx_enable_bit;
				reg_rdata[`UIRP_MODE_IR]  <= infrared_mode_select;
			end else if (hit(reg_addr, `UIRP_ADDR_BAUD_GEN)) begin
				reg_rdata <= {1'b0, baud_src_sel, baud_div_sel} & `UIRP_BAUD_RW_MASK;
			end else if (hit(reg_addr, `UIRP_ADDR_STATUS)) begin
				reg_rdata[`UIRP_ST_OVR]  <= rx_overrun;
				reg_rdata[`UIRP_ST_FE]   <= rx_frame_err;
				reg_rdata[`UIRP_ST_RXF]  <= rx_full;
				reg_rdata[`UIRP_ST_TXF]  <= !fifo_in_ready;
				reg_rdata[`UIRP_ST_BUSY] <= (tx_st != uirp_pkg::UIRP_TX_IDLE);
			end else if (hit(reg_addr, `UIRP_ADDR_RX_DATA)) begin
				reg_rdata <= rx_data;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			pulse_ticks <= 6'h00;
		end else if (!ir_pulse) begin
			pulse_ticks <= 6'h00;
		end else if (src_tick) begin
			pulse_ticks <= pulse_ticks + 6'h01;
		end
	end

	AST_DIR_RESET: assert property (@(posedge clk_sys) $rose(rst_n) |-> port2_direction == `UIRP_RST_PORT2_DIR)
		else $error("direction register not all ones after reset");
	AST_DIR_TO_OE: assert property (@(posedge clk_sys) disable iff (!rst_n)
		reg_wr && hit(reg_addr, `UIRP_ADDR_PORT2_DIR) |=> ##1 pin_oe_n == $past(reg_wdata[5:0], 2))
		else $error("pin enables do not follow direction write");
	AST_FRAME_LEN: assert property (@(posedge clk_sys) disable iff (!rst_n)
		tx_st == uirp_pkg::UIRP_TX_DATA && tx_wrap && tx_bit == 3'h7 |=> tx_st == uirp_pkg::UIRP_TX_STOP && tx_level)
		else $error("stop bit not after eighth data bit");
	AST_PULSE_WIDTH: assert property (@(posedge clk_sys) disable iff (!rst_n)
		$fell(ir_pulse) && $past(tx_st) == tx_st |-> pulse_ticks == pulse_len)
		else $error("infrared pulse width wrong");
	AST_PULSE_MID: assert property (@(posedge clk_sys) disable iff (!rst_n)
		$rose(ir_pulse) |-> tx_phase == half_len)
		else $error("infrared pulse not at mid-bit");
	AST_IR_RATE: assert property (@(posedge clk_sys) disable iff (!rst_n)
		{1'b0, baud_src_sel, baud_div_sel} == `UIRP_IR_BAUD_SETTING |->
		(32'(bit_len) << 1) == `UIRP_IR_BIT_FX_CYCLES && src_tick == prescale[0])
		else $error("infrared setting does not give 64 clocks per bit");
	AST_RX_LAG: assert property (@(posedge clk_sys) disable iff (!rst_n)
		infrared_mode_select && pin_sync[3] && !pin_prev[3] |=> !rx_line [*2])
		else $error("received pulse did not lower the internal line");
	AST_UART_LEVEL: assert property (@(posedge clk_sys) disable iff (!rst_n)
		tx_enable_bit && !infrared_mode_select && !port2_latch[4] |=> pin_out[4] == $past(tx_level))
		else $error("UART mode pin not following bit level");
	AST_DIV_CLAMP: assert property (@(posedge clk_sys) disable iff (!rst_n)
		baud_div_sel >= 4'hE |-> bit_len == 6'h3C)
		else $error("divider beyond 30");
	AST_ONE_NO_PULSE: assert property (@(posedge clk_sys) disable iff (!rst_n)
		tx_level && infrared_mode_select && tx_enable_bit && !port2_latch[`UIRP_PIN_TX] |=> !pin_out[`UIRP_PIN_TX])
		else $error("pulse sent for a one bit");
	COV_IR_PULSE: cover property (@(posedge clk_sys) disable iff (!rst_n) $rose(ir_pulse));
	COV_RX_BYTE: cover property (@(posedge clk_sys) disable iff (!rst_n) rx_store && infrared_mode_select);
	COV_FIFO_FULL: cover property (@(posedge clk_sys) disable iff (!rst_n) !fifo_in_ready);
endmodule : uirp_top
`default_nettype wire

// >>> uirp_regs.svh
// Purpose: Register map, field positions, reset values and timing counts of the infrared pin and pulse block.
// Assumes: Byte-wide registers on a 16-bit CPU address.
// Notes:   Definitions only.
`ifndef UIRP_REGS_SVH
`define UIRP_REGS_SVH
`define UIRP_ADDR_PORT2_DIR     16'hFF22
`define UIRP_ADDR_PORT2_LATCH   16'hFF02
`define UIRP_ADDR_SERIAL_MODE   16'hFFA0
`define UIRP_ADDR_STATUS        16'hFFA1
`define UIRP_ADDR_BAUD_GEN      16'hFFA2
`define UIRP_ADDR_TX_DATA       16'hFFA4
`define UIRP_ADDR_RX_DATA       16'hFFA5
`define UIRP_RST_PORT2_DIR      8'hFF
`define UIRP_RST_ZERO           8'h00
`define UIRP_IR_BAUD_SETTING    8'h10
`define UIRP_DIR_FIXED_MASK     8'hC0
`define UIRP_BAUD_RW_MASK       8'h7F
`define UIRP_MODE_TXE           7
`define UIRP_MODE_RXE           6
`define UIRP_MODE_IR            0
`define UIRP_ST_OVR             0
`define UIRP_ST_FE              1
`define UIRP_ST_RXF             4
`define UIRP_ST_TXF             5
`define UIRP_ST_BUSY            6
`define UIRP_BAUD_SRC_HI        6
`define UIRP_BAUD_SRC_LO        4
`define UIRP_BAUD_DIV_HI        3
`define UIRP_BAUD_DIV_LO        0
`define UIRP_PIN_RX             3
`define UIRP_PIN_TX             4
`define UIRP_PIN_EXT            5
`define UIRP_PIN_COUNT          6
`define UIRP_DIV_BASE           5'h10
`define UIRP_DIV_MAX            4'hE
`define UIRP_PULSE_NUM          8'h03
`define UIRP_PULSE_SHIFT        4
`define UIRP_DATA_BITS          8
`define UIRP_FIFO_DEPTH         4
`define UIRP_REF_FX_HZ          7372800
`define UIRP_IR_BAUD_BPS        115200
`define UIRP_IR_BIT_FX_CYCLES   (`UIRP_REF_FX_HZ / `UIRP_IR_BAUD_BPS)
`define UIRP_CLK_HZ             25000000
`endif

// >>> uirp_pkg.sv
// Purpose: Types shared by the infrared pin and pulse block.
// Assumes: Constants live in uirp_regs.svh.
// Notes:   One-hot state codes.
package uirp_pkg;
	typedef enum logic [3:0] {
		UIRP_TX_IDLE  = 4'h1,
		UIRP_TX_START = 4'h2,
		UIRP_TX_DATA  = 4'h4,
		UIRP_TX_STOP  = 4'h8
	} uirp_tx_state_e;
	typedef enum logic [3:0] {
		UIRP_RX_IDLE  = 4'h1,
		UIRP_RX_START = 4'h2,
		UIRP_RX_DATA  = 4'h4,
		UIRP_RX_STOP  = 4'h8
	} uirp_rx_state_e;
endpackage : uirp_pkg

// >>> uirp_fifo.sv
// Purpose: Small valid/ready FIFO for transmit bytes.
// Assumes: Depth is a power of two.
// Notes:   Full and empty come from a registered count.
`timescale 1ns/1ps
`default_nettype none
module uirp_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
) (
	// Clock and reset
	input  wire logic             clk_sys,
	input  wire logic             rst_n,
	// Fill side
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// Drain side
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr;
	logic [AW-1:0]    rd_ptr;
	logic [AW:0]      count;
	logic             push;
	logic             pop;

	assign in_ready  = (count != DEPTH[AW:0]);
	assign out_valid = (count != '0);
	assign out_data  = mem[rd_ptr];
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;

	always_ff @(posedge clk_sys) begin
		if (push) begin
			mem[wr_ptr] <= in_data;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end else begin
			if (push) begin
				wr_ptr <= wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= rd_ptr + 1'b1;
			end
			if (push && !pop) begin
				count <= count + 1'b1;
			end else if (pop && !push) begin
				count <= count - 1'b1;
			end
		end
	end
endmodule : uirp_fifo
`default_nettype wire

// >>> uirp_ir_partner.sv
// Purpose: Far-side model of the infrared transceiver or remote UART line that feeds the receive pin.
// Assumes: Bit length is given in system clocks by the caller.
// Notes:   Infrared idle is low and UART idle is high; the line is always actively driven.
`timescale 1ns/1ps
`default_nettype none
module uirp_ir_partner (
	// Clock
	input  wire logic clk_sys,
	// Line towards the receive pin
	output logic      line
);
	initial line = 1'b0;

	task automatic hold(input logic lvl);
		@(posedge clk_sys);
		line <= lvl;
	endtask : hold

	// Slow or prompt answers come from the bit length the caller picks
	task automatic send(input logic [7:0] v, input bit ir, input int bl);
		logic [9:0] fr;
		int         k;
		fr = {1'b1, v, 1'b0};
		@(posedge clk_sys);
		line <= !ir;
		repeat (bl) @(posedge clk_sys);
		for (k = 0; k < 10; k++) begin
			if (!ir) begin
				line <= fr[k];
				repeat (bl) @(posedge clk_sys);
			end else if (fr[k]) begin
				repeat (bl) @(posedge clk_sys);
			end else begin
				repeat (bl / 2) @(posedge clk_sys);
				line <= 1'b1;
				repeat (3 * bl / 16) @(posedge clk_sys);
				line <= 1'b0;
				repeat (bl - bl / 2 - 3 * bl / 16) @(posedge clk_sys);
			end
		end
		line <= !ir;
	endtask : send
endmodule : uirp_ir_partner
`default_nettype wire

// >>> tb_uart_infrared_pin_and_pulse_control.sv
// Purpose: Self-checking bench for the port-2 direction and infrared pulse block.
// Assumes: 25 MHz clock; setting 10H gives 64 clocks a bit, setting 21H gives 136.
// Notes:   Transmit bytes are decoded at the pin and compared against a byte queue, or against the written byte in UART mode.
`timescale 1ns/1ps
`default_nettype none
`include "uirp_regs.svh"
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_fail++; $display("FAIL %0t got %h exp %h", $time, (g), (e)); end end
module tb_uart_infrared_pin_and_pulse_control;
	logic        clk_sys = 1'b0;
	logic        rst_n = 1'b0;
	logic [15:0] reg_addr = 16'h0000;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic [7:0]  reg_wdata = 8'h00;
	logic [7:0]  reg_rdata;
	wire  [5:0]  pin_in;
	logic [5:0]  pin_out;
	logic [5:0]  pin_oe_n;
	logic [2:0]  misc = 3'h0;
	logic        rx_line;
	int          n_fail = 0;
	int          checked = 0;
	int          cyc = 0;
	int          i;
	int          n;
	integer      seed = 84;
	logic [7:0]  exp_q[$];
	logic [7:0]  d;
	logic [7:0]  b;

	// Each pin sees its own drive when enabled, else the outside level
	wire [5:0] pad = {1'b0, 1'b1, rx_line, misc};
	assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & pad);

	always #20 clk_sys = ~clk_sys;

	always @(posedge clk_sys) begin
		cyc++;
		if (cyc > 20000) begin
			n_fail++;
			final_report();
		end
	end

	uirp_top dut_u (
		.clk_sys   (clk_sys),
		.rst_n     (rst_n),
		.reg_addr  (reg_addr),
		.reg_wr    (reg_wr),
		.reg_rd    (reg_rd),
		.reg_wdata (reg_wdata),
		.reg_rdata (reg_rdata),
		.pin_in    (pin_in),
		.pin_out   (pin_out),
		.pin_oe_n  (pin_oe_n)
	);

	uirp_ir_partner peer_u (
		.clk_sys (clk_sys),
		.line    (rx_line)
	);

	task automatic wr(input logic [15:0] a, input logic [7:0] v);
		@(posedge clk_sys);
		reg_addr  <= a;
		reg_wdata <= v;
		reg_wr    <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [15:0] a, output logic [7:0] v);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1;
		v = reg_rdata;
	endtask : rd

	task automatic poll(input int bitn, input logic lvl);
		int j;
		for (j = 0; j < 400; j++) begin
			rd(`UIRP_ADDR_STATUS, d);
			if (d[bitn] === lvl) break;
		end
	endtask : poll

	// Decode one frame from the transmit pin; sampling is timed from the first start-bit edge
	task automatic grab(input bit ir, input int bl, output logic [7:0] v);
		int   t0;
		int   w;
		int   k;
		int   j;
		logic s;
		v = 8'h00;
		for (j = 0; j < 4000 && pin_out[4] !== ir; j++) begin
			@(posedge clk_sys);
			#1;
		end
		t0 = cyc;
		w = 0;
		while (ir && pin_out[4] === 1'b1 && w < 100) begin
			@(posedge clk_sys);
			#1;
			w++;
		end
		if (ir) `CHK(w, 3 * bl / 16)
		for (k = 1; k < 10; k++) begin
			while (cyc < t0 + k * bl + (ir ? 3 : bl / 2)) begin
				@(posedge clk_sys);
				#1;
			end
			s = ir ? !pin_out[4] : pin_out[4];
			if (k < 9) v[k-1] = s;
			else `CHK(s, 1'b1)
		end
	endtask : grab

	task automatic final_report;
		$display("comparisons %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : final_report

	initial begin
		repeat (2) @(posedge clk_sys);
		rst_n <= 1'b1;
		#1;
		`CHK(pin_oe_n, 6'h3F)
		rd(`UIRP_ADDR_PORT2_DIR, d);
		`CHK(d, `UIRP_RST_PORT2_DIR)
		rd(16'h1234, d);
		`CHK(d, 8'h00)
		$display("test reset done");

		repeat (6) begin
			b = $random(seed);
			misc <= $random(seed);
			wr(`UIRP_ADDR_PORT2_DIR, b);
			rd(`UIRP_ADDR_PORT2_DIR, d);
			`CHK(d, b | `UIRP_DIR_FIXED_MASK)
			`CHK(pin_oe_n, b[5:0])
		end
		$display("test direction done");

		// Fill with the transmitter off so the count of accepted bytes is exact
		wr(`UIRP_ADDR_PORT2_LATCH, 8'h10);
		wr(`UIRP_ADDR_PORT2_DIR, 8'hEF);
		wr(`UIRP_ADDR_BAUD_GEN, `UIRP_IR_BAUD_SETTING);
		wr(`UIRP_ADDR_SERIAL_MODE, 8'h41);
		rd(`UIRP_ADDR_STATUS, d);
		`CHK(pin_out[4], 1'b1)
		wr(`UIRP_ADDR_PORT2_LATCH, 8'h00);
		n = 0;
		for (i = 0; i < 8; i++) begin
			rd(`UIRP_ADDR_STATUS, d);
			if (d[`UIRP_ST_TXF] === 1'b1) break;
			b = $random(seed);
			wr(`UIRP_ADDR_TX_DATA, b);
			exp_q.push_back(b);
			n++;
		end
		`CHK(n, `UIRP_FIFO_DEPTH)
		wr(`UIRP_ADDR_TX_DATA, 8'h5A);
		wr(`UIRP_ADDR_SERIAL_MODE, 8'hC1);
		while (exp_q.size() > 0) begin
			grab(1, 64, d);
			`CHK(d, exp_q.pop_front())
		end
		repeat (64) @(posedge clk_sys);
		rd(`UIRP_ADDR_STATUS, d);
		`CHK(d[`UIRP_ST_TXF], 1'b0)
		`CHK(d[`UIRP_ST_BUSY], 1'b0)
		$display("test infrared transmit done");

		repeat (2) begin
			b = $random(seed);
			peer_u.send(b, 1, 64);
			poll(`UIRP_ST_RXF, 1'b1);
			rd(`UIRP_ADDR_RX_DATA, d);
			`CHK(d, b)
		end
		$display("test infrared receive done");

		// Quiet the receiver before the line changes idle level
		wr(`UIRP_ADDR_SERIAL_MODE, 8'h00);
		peer_u.hold(1'b1);
		wr(`UIRP_ADDR_BAUD_GEN, 8'h7F);
		rd(`UIRP_ADDR_BAUD_GEN, d);
		`CHK(d, 8'h7F)
		wr(`UIRP_ADDR_BAUD_GEN, 8'h21);
		wr(`UIRP_ADDR_SERIAL_MODE, 8'hC0);
		repeat (8) @(posedge clk_sys);
		b = $random(seed);
		wr(`UIRP_ADDR_TX_DATA, b);
		grab(0, 136, d);
		`CHK(d, b)
		b = $random(seed);
		peer_u.send(b, 0, 136);
		poll(`UIRP_ST_RXF, 1'b1);
		rd(`UIRP_ADDR_RX_DATA, d);
		`CHK(d, b)
		$display("test uart mode done");
		final_report();
	end
endmodule : tb_uart_infrared_pin_and_pulse_control
`default_nettype wire
